// ===== adcdma_ctrl.v
// adc control and dma capture engine: registers, converter sequencing, sram walk
// assumes core sfr port, external sram on a muxed bus with one-cycle access
`timescale 1ns/1ps
`include "adcdma_regs.vh"
module adcdma_ctrl (
    input wire core_clk_in,
    input wire nrst_in,
    input wire sfr_wr_in,
    input wire sfr_rd_in,
    input wire [7:0] sfr_addr_in,
    input wire [7:0] sfr_wdata_in,
    output reg [7:0] sfr_rdata_out,
    input wire [31:0] factory_cal_in,
    input wire timer2_ovf_in,
    input wire external_convert_start_pin_n_in,
    input wire dac_on_in,
    input wire [11:0] adc_code_in,
    output reg [3:0] adc_channel_out,
    output reg adc_sample_out,
    output reg [31:0] cal_out,
    output reg vref_on_out,
    input wire core_port_req_in,
    input wire core_port_wr_in,
    input wire [23:0] core_port_addr_in,
    input wire [7:0] core_port_wdata_in,
    output reg [23:0] ext_addr_out,
    output reg [7:0] ext_data_out,
    output reg ext_data_oe_n_out,
    input wire [7:0] ext_data_in,
    output reg ext_rd_n_out,
    output reg ext_wr_n_out,
    output reg dma_active_out
);
    localparam S_IDLE = 7'h01;
    localparam S_FETCH = 7'h02;
    localparam S_WAIT = 7'h04;
    localparam S_CONV = 7'h08;
    localparam S_WRH = 7'h10;
    localparam S_WRL = 7'h20;
    localparam S_DONE = 7'h40;

    reg [7:0] timing_r;
    reg [7:0] mode_r;
    reg busy_r;
    reg [7:0] res_h_r;
    reg [7:0] res_l_r;
    reg [23:0] ptr_r;
    reg [23:0] wb_ptr_r;
    reg [6:0] st_r;
    reg [2:0] div_r;
    reg [5:0] conv_cnt_r;
    reg converting_r;
    reg cal_run_r;
    reg [3:0] ch_r;
    reg ext_q_r;
    reg cal_loaded_r;
    reg [1:0] wstep_r;

    // adc clock enable from the master clock divider
    function [2:0] div_mask;
        input [1:0] sel;
        begin
            case (sel)
                2'd0: div_mask = 3'h0;
                2'd1: div_mask = 3'h1;
                2'd2: div_mask = 3'h3;
                default: div_mask = 3'h7;
            endcase
        end
    endfunction
    wire adc_tick = ((div_r & div_mask(timing_r[5:4])) == 3'h0);
    wire [5:0] conv_len = `ADCDMA_CONV_CLKS + {3'h0, 1'b0, timing_r[3:2]} + 6'd1;
    wire ext_fall = ext_q_r && !external_convert_start_pin_n_in;
    wire trig = (timing_r[`ADCDMA_BIT_T2] && timer2_ovf_in)
        || (timing_r[`ADCDMA_BIT_EXT] && ext_fall);
    wire wr_timing = sfr_wr_in && sfr_addr_in == `ADCDMA_ADDR_TIMING;
    wire wr_mode = sfr_wr_in && sfr_addr_in == `ADCDMA_ADDR_MODE;
    wire wr_status = sfr_wr_in && sfr_addr_in == `ADCDMA_ADDR_STATUS;
    wire dma_on = mode_r[`ADCDMA_BIT_DMA];
    wire conv_end = converting_r && adc_tick && conv_cnt_r == 6'd1;
    wire conv_start_dma = (st_r == S_WAIT) && !converting_r
        && (trig || mode_r[`ADCDMA_BIT_CONT]);
    wire conv_start_sw = !dma_on && !converting_r
        && (mode_r[`ADCDMA_BIT_SINGLE] || trig || mode_r[`ADCDMA_BIT_CONT]);
    wire cal_start = wr_status && sfr_wdata_in[`ADCDMA_BIT_CALIBRATION_START] && !converting_r;
    wire [15:0] res_word = {ch_r, adc_code_in};
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [15:0] fifo_out_data;
    reg fifo_pop;

    // results queue so a slow sram cycle never drops a sample
    adcdma_fifo #(.WIDTH(16), .DEPTH(`ADCDMA_FIFO_DEPTH), .AW(`ADCDMA_FIFO_AW)) u_fifo (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .in_valid_in(conv_end && dma_on && !cal_run_r),
        .in_ready_out(fifo_in_ready),
        .in_data_in(res_word),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_out_data)
    );

    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            timing_r <= `ADCDMA_RST_TIMING;
            mode_r <= `ADCDMA_RST_MODE;
            busy_r <= 1'b0;
            res_h_r <= 8'h00;
            res_l_r <= 8'h00;
            ptr_r <= 24'h000000;
            wb_ptr_r <= 24'h000000;
            st_r <= S_IDLE;
            div_r <= 3'h0;
            conv_cnt_r <= 6'h00;
            converting_r <= 1'b0;
            cal_run_r <= 1'b0;
            ch_r <= 4'h0;
            ext_q_r <= 1'b1;
            cal_loaded_r <= 1'b0;
            cal_out <= 32'h00000000;
            wstep_r <= 2'd0;
            adc_channel_out <= 4'h0;
            adc_sample_out <= 1'b0;
            vref_on_out <= 1'b0;
            sfr_rdata_out <= 8'h00;
            ext_addr_out <= 24'h000000;
            ext_data_out <= 8'h00;
            ext_data_oe_n_out <= 1'b1;
            ext_rd_n_out <= 1'b1;
            ext_wr_n_out <= 1'b1;
            dma_active_out <= 1'b0;
            fifo_pop <= 1'b0;
        end else begin
            div_r <= div_r + 3'h1;
            ext_q_r <= external_convert_start_pin_n_in;
            adc_sample_out <= 1'b0;
            fifo_pop <= 1'b0;
            // factory constants captured after reset release, not under it
            if (!cal_loaded_r) begin
                cal_out <= factory_cal_in;
                cal_loaded_r <= 1'b1;
            end
            if (sfr_wr_in) begin
                case (sfr_addr_in)
                    `ADCDMA_ADDR_CALIBRATION_MODE_LOW: cal_out[7:0] <= sfr_wdata_in;
                    `ADCDMA_ADDR_CALIBRATION_MODE_HIGH: cal_out[15:8] <= sfr_wdata_in;
                    `ADCDMA_ADDR_CAL2: cal_out[23:16] <= sfr_wdata_in;
                    `ADCDMA_ADDR_CAL3: cal_out[31:24] <= sfr_wdata_in;
                    `ADCDMA_ADDR_PTR_L: ptr_r[7:0] <= sfr_wdata_in;
                    `ADCDMA_ADDR_PTR_H: ptr_r[15:8] <= sfr_wdata_in;
                    `ADCDMA_ADDR_PTR_P: ptr_r[23:16] <= sfr_wdata_in;
                    default: ;
                endcase
            end
            if (wr_timing) begin
                timing_r <= sfr_wdata_in;
            end
            vref_on_out <= (timing_r[7:6] != 2'b00) || dac_on_in;
            // converter sequencing; done flag set wins over software clear
            if (wr_mode) begin
                mode_r <= sfr_wdata_in;
            end
            if (conv_start_sw || conv_start_dma || cal_start) begin
                converting_r <= 1'b1;
                busy_r <= 1'b1;
                cal_run_r <= cal_start;
                conv_cnt_r <= conv_len;
                adc_channel_out <= dma_on ? ch_r : mode_r[3:0];
                if (!dma_on) begin
                    ch_r <= mode_r[3:0];
                end
                if (mode_r[`ADCDMA_BIT_SINGLE] && !dma_on && !wr_mode) begin
                    mode_r[`ADCDMA_BIT_SINGLE] <= 1'b0;
                end
            end else if (converting_r && adc_tick) begin
                conv_cnt_r <= conv_cnt_r - 6'd1;
                if (conv_cnt_r == 6'd1) begin
                    converting_r <= 1'b0;
                    busy_r <= 1'b0;
                    cal_run_r <= 1'b0;
                    if (!cal_run_r) begin
                        adc_sample_out <= 1'b1;
                        res_h_r <= {ch_r, adc_code_in[11:8]};
                        res_l_r <= adc_code_in[7:0];
                        if (!dma_on) begin
                            mode_r[`ADCDMA_BIT_DONE] <= 1'b1;
                        end
                    end
                end
            end
            // dma walk over the external table; core runs on untouched
            ext_rd_n_out <= 1'b1;
            ext_wr_n_out <= 1'b1;
            case (st_r)
                S_IDLE: begin
                    if (dma_on) begin
                        st_r <= S_FETCH;
                        wb_ptr_r <= ptr_r;
                        dma_active_out <= 1'b1;
                        ext_addr_out <= ptr_r;
                        ext_rd_n_out <= 1'b0;
                        ext_data_oe_n_out <= 1'b1;
                    end
                end
                S_FETCH: begin
                    // high byte first carries the channel code
                    if (ext_data_in[7:4] == `ADCDMA_CH_STOP) begin
                        st_r <= S_DONE;
                    end else begin
                        ch_r <= ext_data_in[7:4];
                        st_r <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (conv_start_dma) begin
                        st_r <= S_CONV;
                    end
                end
                S_CONV: begin
                    if (fifo_out_valid && !fifo_pop) begin
                        fifo_pop <= 1'b1;
                        ext_addr_out <= wb_ptr_r;
                        ext_data_out <= fifo_out_data[15:8];
                        ext_data_oe_n_out <= 1'b0;
                        ext_wr_n_out <= 1'b0;
                        st_r <= S_WRH;
                    end
                end
                S_WRH: begin
                    ext_addr_out <= wb_ptr_r + 24'h000001;
                    ext_data_out <= fifo_out_data[7:0];
                    ext_wr_n_out <= 1'b0;
                    st_r <= S_WRL;
                end
                S_WRL: begin
                    wb_ptr_r <= wb_ptr_r + 24'h000002;
                    ext_addr_out <= wb_ptr_r + 24'h000002;
                    ext_data_oe_n_out <= 1'b1;
                    ext_rd_n_out <= 1'b0;
                    st_r <= S_FETCH;
                end
                S_DONE: begin
                    mode_r[`ADCDMA_BIT_DONE] <= 1'b1;
                    mode_r[`ADCDMA_BIT_DMA] <= 1'b0;
                    dma_active_out <= 1'b0;
                    st_r <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
            // core port cycles pass only while dma is idle
            if (st_r == S_IDLE && !dma_on && core_port_req_in) begin
                ext_addr_out <= core_port_addr_in;
                ext_data_out <= core_port_wdata_in;
                ext_data_oe_n_out <= !core_port_wr_in;
                ext_wr_n_out <= !core_port_wr_in;
                ext_rd_n_out <= core_port_wr_in;
            end
            if (sfr_rd_in) begin
                case (sfr_addr_in)
                    `ADCDMA_ADDR_TIMING: sfr_rdata_out <= timing_r;
                    `ADCDMA_ADDR_MODE: sfr_rdata_out <= mode_r;
                    `ADCDMA_ADDR_STATUS: sfr_rdata_out <= {busy_r, 7'h00};
                    `ADCDMA_ADDR_RES_H: sfr_rdata_out <= res_h_r;
                    `ADCDMA_ADDR_RES_L: sfr_rdata_out <= res_l_r;
                    `ADCDMA_ADDR_PTR_L: sfr_rdata_out <= ptr_r[7:0];
                    `ADCDMA_ADDR_PTR_H: sfr_rdata_out <= ptr_r[15:8];
                    `ADCDMA_ADDR_PTR_P: sfr_rdata_out <= ptr_r[23:16];
                    `ADCDMA_ADDR_CALIBRATION_MODE_LOW: sfr_rdata_out <= cal_out[7:0];
                    `ADCDMA_ADDR_CALIBRATION_MODE_HIGH: sfr_rdata_out <= cal_out[15:8];
                    `ADCDMA_ADDR_CAL2: sfr_rdata_out <= cal_out[23:16];
                    `ADCDMA_ADDR_CAL3: sfr_rdata_out <= cal_out[31:24];
                    default: sfr_rdata_out <= 8'h00;
                endcase
            end
        end
    end
endmodule // adcdma_ctrl

// ===== adcdma_regs.vh
// register map, field positions, reset values and timing counts for the adc dma block
// assumes a byte-wide special function register port from the core
`ifndef ADCDMA_REGS_VH
`define ADCDMA_REGS_VH
`define ADCDMA_ADDR_TIMING 8'hEF
`define ADCDMA_ADDR_MODE 8'hD8
`define ADCDMA_ADDR_STATUS 8'hF5
`define ADCDMA_ADDR_RES_H 8'hDA
`define ADCDMA_ADDR_RES_L 8'hD9
`define ADCDMA_ADDR_PTR_L 8'hD2
`define ADCDMA_ADDR_PTR_H 8'hD3
`define ADCDMA_ADDR_PTR_P 8'hD4
`define ADCDMA_ADDR_CALIBRATION_MODE_LOW 8'hF1
`define ADCDMA_ADDR_CALIBRATION_MODE_HIGH 8'hF2
`define ADCDMA_ADDR_CAL2 8'hF3
`define ADCDMA_ADDR_CAL3 8'hF4
`define ADCDMA_RST_TIMING 8'h20
`define ADCDMA_RST_MODE 8'h00
`define ADCDMA_RST_STATUS 8'h00
`define ADCDMA_BIT_DONE 7
`define ADCDMA_BIT_DMA 6
`define ADCDMA_BIT_CONT 5
`define ADCDMA_BIT_SINGLE 4
`define ADCDMA_BIT_BUSY 7
`define ADCDMA_BIT_CALIBRATION_START 0
`define ADCDMA_BIT_T2 1
`define ADCDMA_BIT_EXT 0
`define ADCDMA_CH_STOP 4'hF
`define ADCDMA_CONV_CLKS 6'h10
`define ADCDMA_FIFO_DEPTH 16
`define ADCDMA_FIFO_AW 4
`endif

// ===== adcdma_fifo.v
// result fifo between converter and external write-back
// assumes one clock; write side stalls when full
`timescale 1ns/1ps
module adcdma_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire core_clk_in,
    input wire nrst_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output reg out_valid_out,
    input wire out_ready_in,
    output reg [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wp_r;
    reg [AW:0] rp_r;
    wire [AW:0] cnt = wp_r - rp_r;
    wire full = (cnt == DEPTH[AW:0]);
    wire empty = (cnt == {(AW+1){1'b0}});
    wire pop = (!out_valid_out || out_ready_in) && !empty;
    assign in_ready_out = !full;
    always @(posedge core_clk_in) begin
        if (in_valid_in && !full) begin
            mem[wp_r[AW-1:0]] <= in_data_in;
        end
    end
    // read data registered so the drain side sees a flop
    always @(posedge core_clk_in) begin
        if (!nrst_in) begin
            wp_r <= {(AW+1){1'b0}};
            rp_r <= {(AW+1){1'b0}};
            out_valid_out <= 1'b0;
            out_data_out <= {WIDTH{1'b0}};
        end else begin
            if (in_valid_in && !full) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                out_data_out <= mem[rp_r[AW-1:0]];
                rp_r <= rp_r + 1'b1;
                out_valid_out <= 1'b1;
            end else if (out_ready_in) begin
                out_valid_out <= 1'b0;
            end
        end
    end
endmodule // adcdma_fifo

// ===== adcdma_checker.sv
// port assertions for the adc dma control block
// assumes a bind onto adcdma_ctrl and a sync active low reset
`timescale 1ns/1ps
`include "adcdma_regs.vh"
module adcdma_checker (
    input wire core_clk_in,
    input wire nrst_in,
    input wire sfr_wr_in,
    input wire sfr_rd_in,
    input wire [7:0] sfr_addr_in,
    input wire [7:0] sfr_wdata_in,
    input wire [7:0] sfr_rdata_out,
    input wire [31:0] factory_cal_in,
    input wire dac_on_in,
    input wire adc_sample_out,
    input wire [31:0] cal_out,
    input wire vref_on_out,
    input wire core_port_req_in,
    input wire [23:0] core_port_addr_in,
    input wire [23:0] ext_addr_out,
    input wire ext_data_oe_n_out,
    input wire [7:0] ext_data_in,
    input wire ext_rd_n_out,
    input wire ext_wr_n_out,
    input wire dma_active_out
);
    reg [23:0] rd_addr_r;
    reg [23:0] wr_addr_r;
    reg wr_idx_r;
    reg had_wr_r;
    // write pair position; no reset of the addresses needed, flags gate them
    always @(posedge core_clk_in) begin
        if (!ext_rd_n_out)
            rd_addr_r <= ext_addr_out;
        if (!ext_wr_n_out)
            wr_addr_r <= ext_addr_out;
        had_wr_r <= nrst_in && dma_active_out && (had_wr_r || !ext_wr_n_out);
        wr_idx_r <= nrst_in && (wr_idx_r ^ !ext_wr_n_out);
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);
    AST_STS_LOW: assert property (sfr_rd_in && sfr_addr_in == `ADCDMA_ADDR_STATUS
        |=> sfr_rdata_out[6:0] == 7'h00) else $error("status low bits not zero");
    AST_CAL_FACTORY: assert property ($rose(nrst_in) |=> cal_out == $past(factory_cal_in))
        else $error("factory calibration not loaded");
    AST_CAL_WRITE: assert property (sfr_wr_in && sfr_addr_in == `ADCDMA_ADDR_CALIBRATION_MODE_LOW
        |=> cal_out[7:0] == $past(sfr_wdata_in)) else $error("calibration write lost");
    AST_WR_SAME: assert property (dma_active_out && !ext_wr_n_out
        |-> ext_addr_out == rd_addr_r + {23'h0, wr_idx_r}) else $error("write-back address");
    AST_NEXT_RD: assert property (dma_active_out && !ext_rd_n_out && had_wr_r
        |-> ext_addr_out == wr_addr_r + 24'h1) else $error("next entry address");
    AST_GATED: assert property (dma_active_out && core_port_req_in
        |=> ext_addr_out != $past(core_port_addr_in)) else $error("core access reached pins");
    AST_WR_DRIVE: assert property (!ext_wr_n_out |-> !ext_data_oe_n_out)
        else $error("data not driven on write");
    AST_SAMPLE_GAP: assert property (adc_sample_out |=> !adc_sample_out [*8])
        else $error("conversion too short");
    AST_STOP: assert property (dma_active_out && !ext_rd_n_out
        && ext_data_in[7:4] == `ADCDMA_CH_STOP |-> ##[1:3] !dma_active_out)
        else $error("stop code ignored");
    AST_VREF: assert property (dac_on_in && $past(dac_on_in) && $past(nrst_in)
        |-> vref_on_out) else $error("reference off with dac on");
    cover property (adc_sample_out);
    cover property (!ext_wr_n_out);
    cover property (dma_active_out && core_port_req_in);
endmodule // adcdma_checker

// ===== adcdma_sram_model.sv
// external static ram on the multiplexed port bus
// assumes read data is wanted while the read strobe is low, asynchronous read
`timescale 1ns/1ps
module adcdma_sram_model (
    input wire core_clk_in,
    input wire [23:0] addr_in,
    input wire [7:0] data_in,
    input wire oe_n_in,
    input wire rd_n_in,
    input wire wr_n_in,
    output wire [7:0] data_out
);
    // only 64 bytes decoded; tables must sit low in memory
    reg [7:0] mem [0:63];
    reg [7:0] last_r = 8'h00;
    // released bus shows the inverse of the last byte, never a stale value
    assign data_out = !rd_n_in ? mem[addr_in[5:0]] : ~last_r;
    always @(posedge core_clk_in) begin
        if (!rd_n_in)
            last_r <= mem[addr_in[5:0]];
        if (!wr_n_in && !oe_n_in)
            mem[addr_in[5:0]] <= data_in;
    end
endmodule // adcdma_sram_model

// ===== test_adc_dma_capture_control.sv
// self-checking bench for the adc dma control block
// assumes checker and sram model compiled ahead of it
`timescale 1ns/1ps
`include "adcdma_regs.vh"
module test_adc_dma_capture_control;
    localparam [31:0] FACTORY = 32'h1234_5678;
    reg core_clk_in = 1'b0;
    reg nrst_in = 1'b0;
    reg sfr_wr_in = 1'b0;
    reg sfr_rd_in = 1'b0;
    reg [7:0] sfr_addr_in = 8'h00;
    reg [7:0] sfr_wdata_in = 8'h00;
    reg timer2_ovf_in = 1'b0;
    reg ext_start_n = 1'b1;
    reg dac_on_in = 1'b0;
    reg core_port_req_in = 1'b0;
    wire [7:0] sfr_rdata_out, ext_data_out, ext_data_in;
    wire [3:0] adc_channel_out;
    wire [31:0] cal_out;
    wire [23:0] ext_addr_out;
    wire adc_sample_out, vref_on_out, ext_data_oe_n_out, ext_rd_n_out, ext_wr_n_out;
    wire dma_active_out;
    integer fails = 0;
    integer n_tests = 0;
    integer i, n1, n8;
    reg [7:0] v;
    adcdma_ctrl adcdma_ctrl_inst (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_addr_in(sfr_addr_in),
        .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .factory_cal_in(FACTORY),
        .timer2_ovf_in(timer2_ovf_in), .external_convert_start_pin_n_in(ext_start_n),
        .dac_on_in(dac_on_in), .adc_code_in(12'hABC), .adc_channel_out(adc_channel_out),
        .adc_sample_out(adc_sample_out), .cal_out(cal_out), .vref_on_out(vref_on_out),
        .core_port_req_in(core_port_req_in), .core_port_wr_in(1'b1),
        .core_port_addr_in(24'hABCDEF), .core_port_wdata_in(8'h5A),
        .ext_addr_out(ext_addr_out), .ext_data_out(ext_data_out),
        .ext_data_oe_n_out(ext_data_oe_n_out), .ext_data_in(ext_data_in),
        .ext_rd_n_out(ext_rd_n_out), .ext_wr_n_out(ext_wr_n_out), .dma_active_out(dma_active_out));
    adcdma_sram_model adcdma_sram_model_inst (.core_clk_in(core_clk_in), .addr_in(ext_addr_out),
        .data_in(ext_data_out), .oe_n_in(ext_data_oe_n_out), .rd_n_in(ext_rd_n_out),
        .wr_n_in(ext_wr_n_out), .data_out(ext_data_in));
    always #20 core_clk_in = ~core_clk_in;
    task summarize;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task check(input string name, input [31:0] seen, input [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(negedge core_clk_in);
        {sfr_addr_in, sfr_wdata_in, sfr_wr_in} = {a, d, 1'b1};
        @(negedge core_clk_in);
        sfr_wr_in = 1'b0;
    endtask
    task rd(input [7:0] a);
        @(negedge core_clk_in);
        {sfr_addr_in, sfr_rd_in} = {a, 1'b1};
        @(negedge core_clk_in);
        sfr_rd_in = 1'b0;
        v = sfr_rdata_out;
    endtask
    // polls a status bit with a bound; a hang ends the run
    task poll(input [7:0] a, input integer b, input val);
        i = 0;
        rd(a);
        while (v[b] !== val && i < 5000) begin
            rd(a);
            i = i + 1;
        end
        if (i >= 5000) begin
            fails = fails + 1;
            summarize;
        end
    endtask
    task wait_sample(output integer n);
        n = 0;
        while (adc_sample_out !== 1'b1 && n < 2000) begin
            @(negedge core_clk_in);
            n = n + 1;
        end
        if (n >= 2000) begin
            fails = fails + 1;
            summarize;
        end
    endtask
    task t_reset;
        rd(`ADCDMA_ADDR_STATUS);
        check("status", v, `ADCDMA_RST_STATUS);
        rd(`ADCDMA_ADDR_TIMING);
        check("timing", v, `ADCDMA_RST_TIMING);
        rd(8'h80);
        check("unmapped", v, 8'h00);
        check("cal", cal_out, FACTORY);
        check("vref off", vref_on_out, 1'b0);
        dac_on_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        check("vref on", vref_on_out, 1'b1);
        dac_on_in = 1'b0;
    endtask
    task t_cal;
        for (i = 0; i < 4; i = i + 1)
            wr(`ADCDMA_ADDR_CALIBRATION_MODE_LOW + i[7:0], 8'hC0 + i[7:0]);
        check("cal user", cal_out, 32'hC3C2C1C0);
        wr(`ADCDMA_ADDR_STATUS, 8'h7E);
        rd(`ADCDMA_ADDR_STATUS);
        check("reserved", v, 8'h00);
        wr(`ADCDMA_ADDR_STATUS, 8'h01);
        rd(`ADCDMA_ADDR_STATUS);
        check("cal busy", v[7], 1'b1);
        poll(`ADCDMA_ADDR_STATUS, 7, 1'b0);
        check("busy clear", v, 8'h00);
    endtask
    task t_trig;
        wr(`ADCDMA_ADDR_TIMING, 8'h42);
        wr(`ADCDMA_ADDR_MODE, 8'h03);
        check("vref mode", vref_on_out, 1'b1);
        @(negedge core_clk_in) timer2_ovf_in = 1'b1;
        @(negedge core_clk_in) timer2_ovf_in = 1'b0;
        wait_sample(n1);
        check("timer chan", adc_channel_out, 4'h3);
        check("len div1", n1, 17);
        wr(`ADCDMA_ADDR_TIMING, 8'h71);
        wr(`ADCDMA_ADDR_MODE, 8'h05);
        @(negedge core_clk_in) ext_start_n = 1'b0;
        @(negedge core_clk_in) ext_start_n = 1'b1;
        wait_sample(n8);
        check("pin chan", adc_channel_out, 4'h5);
        check("len div8", n8 > 128 && n8 <= 136, 1'b1);
        rd(`ADCDMA_ADDR_RES_H);
        check("res high", v, 8'h5A);
        rd(`ADCDMA_ADDR_RES_L);
        check("res low", v, 8'hBC);
    endtask
    task t_dma;
        for (i = 0; i < 3; i = i + 1)
            adcdma_sram_model_inst.mem[16 + 2 * i] = {4'h2 + 4'h3 * i[3:0], 4'h0};
        adcdma_sram_model_inst.mem[22] = 8'hF0;
        wr(`ADCDMA_ADDR_TIMING, 8'h40);
        wr(`ADCDMA_ADDR_PTR_L, 8'h10);
        wr(`ADCDMA_ADDR_PTR_H, 8'h00);
        wr(`ADCDMA_ADDR_PTR_P, 8'h00);
        wr(`ADCDMA_ADDR_MODE, 8'h60);
        @(negedge core_clk_in) core_port_req_in = 1'b1;
        @(negedge core_clk_in) core_port_req_in = 1'b0;
        poll(`ADCDMA_ADDR_MODE, 7, 1'b1);
        check("dma off", v[6], 1'b0);
        check("walk idle", dma_active_out, 1'b0);
        for (i = 0; i < 3; i = i + 1) begin
            check("entry hi", adcdma_sram_model_inst.mem[16 + 2 * i],
                {4'h2 + 4'h3 * i[3:0], 4'hA});
            check("entry lo", adcdma_sram_model_inst.mem[17 + 2 * i], 8'hBC);
        end
        check("stop kept", adcdma_sram_model_inst.mem[22], 8'hF0);
    endtask
    initial begin
        repeat (6) @(negedge core_clk_in);
        nrst_in = 1'b1;
        @(negedge core_clk_in);
        t_reset;
        t_cal;
        t_trig;
        t_dma;
        summarize;
    end
endmodule // test_adc_dma_capture_control
bind adcdma_ctrl adcdma_checker adcdma_checker_inst (.core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .factory_cal_in(factory_cal_in),
    .dac_on_in(dac_on_in), .adc_sample_out(adc_sample_out), .cal_out(cal_out),
    .vref_on_out(vref_on_out), .core_port_req_in(core_port_req_in),
    .core_port_addr_in(core_port_addr_in), .ext_addr_out(ext_addr_out),
    .ext_data_oe_n_out(ext_data_oe_n_out), .ext_data_in(ext_data_in),
    .ext_rd_n_out(ext_rd_n_out), .ext_wr_n_out(ext_wr_n_out), .dma_active_out(dma_active_out));
